// ==== rtl/hgs_cfg.svh ====
// Purpose: constants for the hardware gate semaphore
// Assumes: one system clock, synchronous reset
// Notes:   gate state 0 means unlocked
`ifndef HGS_CFG_SVH
`define HGS_CFG_SVH
`define HGS_NUM_GATES     16
`define HGS_ADDR_W        4
`define HGS_STATE_W       4
`define HGS_DATA_W        8
`define HGS_MASTER_W      4
`define HGS_STATE_UNLOCK  4'h0
`define HGS_RST_KEY1      8'he2
`define HGS_RST_KEY2      8'h1d
`endif

// ==== rtl/hgs_pkg.sv ====
// Purpose: types for the hardware gate semaphore
// Assumes: hgs_cfg.svh provides widths
// Notes:   none
`include "hgs_cfg.svh"
package hgs_pkg;
    typedef struct packed {
        logic                       wr;
        logic                       rd;
        logic [`HGS_ADDR_W-1:0]     addr;
        logic [`HGS_DATA_W-1:0]     wdata;
        logic [`HGS_MASTER_W-1:0]   master;
    } hgs_req_type;

    typedef struct packed {
        logic                       rvalid;
        logic [`HGS_DATA_W-1:0]     rdata;
        logic                       werr;
    } hgs_rsp_type;

    typedef struct packed {
        logic                       valid;
        logic                       all;
        logic [`HGS_ADDR_W-1:0]     gate;
        logic [`HGS_DATA_W-1:0]     key;
    } hgs_clr_type;

    typedef enum logic [0:0] {
        HGS_RST_IDLE = 1'b0,
        HGS_RST_ARMED = 1'b1
    } hgs_rst_state_type;
endpackage

// ==== rtl/hgs_gate_semaphore.sv ====
// Purpose: sixteen hardware-enforced lock gates reached by several bus masters
// Assumes: one access per cycle, master number presented with every access
// Notes:   reset is a two-write keyed sequence on a separate clear port
//
// Summary of operation
// [R1] sixteen gates appear as a readable and writable byte array
// [R2] each gate is a 4-bit state machine with sixteen states
// [R3] one write locks or unlocks a gate, no further bus cycles
// [R4] writes are checked against master number and written data pattern
// [R5] only the locking master may unlock, by writing zero
// [R6] keyed clear of one gate or all gates
// [R7] unlocked is zero, lock stores master plus one, foreign writes ignored
//
// ------------------------------------------------------------
// constants
// ------------------------------------------------------------
`include "hgs_cfg.svh"

module hgs_gate_semaphore (
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    // gate access port
    input  wire hgs_pkg::hgs_req_type       req,
    output      hgs_pkg::hgs_rsp_type       rsp,
    // secure clear port
    input  wire hgs_pkg::hgs_clr_type       clr,
    output      logic                       clr_armed,
    // gate lock status
    output      logic [`HGS_NUM_GATES-1:0]  gate_locked
);
    import hgs_pkg::*;

    // ------------------------------------------------------------
    // gate state storage
    // ------------------------------------------------------------
    logic [`HGS_STATE_W-1:0]   gate_reg [`HGS_NUM_GATES];
    logic [`HGS_STATE_W-1:0]   cur_state;
    logic [`HGS_STATE_W-1:0]   own_code;
    logic                      own_valid;
    logic                      lock_ok;
    logic                      unlock_ok;
    logic                      wr_ok;
    logic                      clr_step2;
    logic                      clr_one;
    logic                      clr_all;
    logic [`HGS_NUM_GATES-1:0] clr_hit;
    logic [`HGS_NUM_GATES-1:0] wr_hit;
    logic [`HGS_NUM_GATES-1:0] gate_busy;
    hgs_rst_state_type         rst_state_reg;
    logic [`HGS_ADDR_W-1:0]    rst_gate_reg;
    logic                      rst_all_reg;
    logic                      rvalid_reg;
    logic [`HGS_DATA_W-1:0]    rdata_reg;
    logic                      werr_reg;

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    // state of the addressed gate, seen by reads and writes alike
    assign cur_state = gate_reg[req.addr];

    // owner code of the requesting master
    assign own_code  = req.master + `HGS_STATE_W'(1);       // see [R7]

    // the top master number wraps to zero and can never own a gate
    assign own_valid = (own_code != `HGS_STATE_UNLOCK);     // see [R7]

    // lock: free gate, data equal to own code
    always_comb begin
        lock_ok = 1'b0;
        if (cur_state == `HGS_STATE_UNLOCK) begin
            lock_ok = own_valid && (req.wdata == `HGS_DATA_W'(own_code));  // see [R4]
        end
    end

    // unlock: gate held by this master, data all zero
    always_comb begin
        unlock_ok = 1'b0;
        if (own_valid && (cur_state == own_code)) begin
            unlock_ok = (req.wdata == `HGS_DATA_W'(0));     // see [R5]
        end
    end

    // any other write is refused and leaves the gate as it was
    assign wr_ok = lock_ok || unlock_ok;                     // see [R4]

    // ------------------------------------------------------------
    // secure clear sequence
    // ------------------------------------------------------------
    // key state: first key arms, any strobe while armed disarms
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rst_state_reg <= HGS_RST_IDLE;
        end else if (clr.valid) begin
            case (rst_state_reg)
                HGS_RST_IDLE: begin
                    if (clr.key == `HGS_RST_KEY1) begin
                        rst_state_reg <= HGS_RST_ARMED;
                    end
                end
                default: begin
                    rst_state_reg <= HGS_RST_IDLE;
                end
            endcase
        end
    end

    // target of the clear is fixed by the first key only
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rst_gate_reg <= '0;
            rst_all_reg  <= 1'b0;
        end else if (clr.valid && (rst_state_reg == HGS_RST_IDLE)
                     && (clr.key == `HGS_RST_KEY1)) begin
            rst_gate_reg <= clr.gate;
            rst_all_reg  <= clr.all;
        end
    end

    // second key while armed completes the clear
    assign clr_step2 = clr.valid && (rst_state_reg == HGS_RST_ARMED)
                       && (clr.key == `HGS_RST_KEY2);
    assign clr_one   = clr_step2 && !rst_all_reg;            // see [R6]
    assign clr_all   = clr_step2 && rst_all_reg;             // see [R6]

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clr_armed <= 1'b0;
        end else begin
            clr_armed <= (rst_state_reg == HGS_RST_ARMED);
        end
    end

    // ------------------------------------------------------------
    // per-gate state machines
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `HGS_NUM_GATES; g++) begin : gen_gate
            // this gate is the target of the clear or of the write
            assign clr_hit[g] = clr_all || (clr_one && (rst_gate_reg == `HGS_ADDR_W'(g)));
            assign wr_hit[g]  = req.wr && wr_ok && (req.addr == `HGS_ADDR_W'(g));

            // clear wins over a write in the same cycle
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    gate_reg[g] <= `HGS_STATE_UNLOCK;
                end else if (clr_hit[g]) begin
                    gate_reg[g] <= `HGS_STATE_UNLOCK;            // see [R6]
                end else if (wr_hit[g]) begin
                    gate_reg[g] <= req.wdata[`HGS_STATE_W-1:0];  // see [R3], see [R2]
                end
            end

            // gate holds a nonzero owner code
            assign gate_busy[g] = (gate_reg[g] != `HGS_STATE_UNLOCK);
        end
    endgenerate

    // ------------------------------------------------------------
    // lock status
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gate_locked <= '0;
        end else begin
            gate_locked <= gate_busy;
        end
    end

    // ------------------------------------------------------------
    // read answer
    // ------------------------------------------------------------
    // read strobe answered one cycle later
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= req.rd;
        end
    end

    // gate state in the low nibble, zero when no read
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_reg <= '0;
        end else if (req.rd) begin
            rdata_reg <= `HGS_DATA_W'(cur_state);             // see [R1]
        end else begin
            rdata_reg <= '0;
        end
    end

    // ------------------------------------------------------------
    // write refusal
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            werr_reg <= 1'b0;
        end else begin
            werr_reg <= req.wr && !wr_ok;                      // see [R4]
        end
    end

    // ------------------------------------------------------------
    // response port
    // ------------------------------------------------------------
    // every field comes straight from its own flip-flop
    assign rsp = '{rvalid: rvalid_reg, rdata: rdata_reg, werr: werr_reg};
endmodule

// ==== sim/hgs_props.sv ====
// Purpose: port checks for the gate semaphore
// Assumes: sync reset rst, one clock
// Notes:   bound to hgs_gate_semaphore
`include "hgs_cfg.svh"
module hgs_props (
    // watched ports
    input wire logic                      clk_sys,
    input wire logic                      rst,
    input wire hgs_pkg::hgs_req_type      req,
    input wire hgs_pkg::hgs_rsp_type      rsp,
    input wire hgs_pkg::hgs_clr_type      clr,
    input wire logic                      clr_armed,
    input wire logic [`HGS_NUM_GATES-1:0] gate_locked
);
    import hgs_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // all flag of the last clear strobe, i.e. of the first key when armed
    logic step_all_reg;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            step_all_reg <= 1'b0;
        end else if (clr.valid) begin
            step_all_reg <= clr.all;
        end
    end
    AST_READ: assert property (req.rd |=> rsp.rvalid && rsp.rdata[7:4] == 4'h0)
        else $error("read answer missing or wide");
    AST_BADPAT: assert property (req.wr && !clr.valid && req.wdata[7:4] != 4'h0 |=> rsp.werr)
        else $error("bad pattern not refused");
    AST_WERR: assert property (rsp.werr |-> $past(req.wr))
        else $error("refusal without a write");
    AST_LOCK: assert property (req.wr && !clr.valid && gate_locked == 16'h0 && !$past(req.wr)
        && req.master != 4'hf && req.wdata == {4'h0, req.master + 4'h1}
        |=> !rsp.werr ##1 gate_locked != 16'h0)
        else $error("valid lock not taken");
    AST_CLRALL: assert property (clr.valid && step_all_reg && clr.key == `HGS_RST_KEY2
        && clr_armed && !$past(clr.valid) ##1 !req.wr |=> gate_locked == 16'h0)
        else $error("clear all left a gate locked");
    AST_QUIET: assert property (!req.wr && !clr.valid ##1 !req.wr && !clr.valid
        |=> $stable(gate_locked))
        else $error("gate changed without a write");
    cover property (rsp.werr);
    cover property (rsp.rvalid);
    cover property (clr_armed ##1 !clr_armed);
endmodule
bind hgs_gate_semaphore hgs_props u_props (.clk_sys(clk_sys), .rst(rst), .req(req),
    .rsp(rsp), .clr(clr), .clr_armed(clr_armed), .gate_locked(gate_locked));

// ==== sim/hgs_core_model.sv ====
// Purpose: bus master issuing single gate accesses
// Assumes: one access at a time
// Notes:   request held for one taking edge
module hgs_core_model (
    // clock
    input  wire logic            clk_sys,
    // request
    output hgs_pkg::hgs_req_type req
);
    import hgs_pkg::*;
    initial req = '0;
    task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d,
                          input logic [3:0] m);
        @(posedge clk_sys);
        req <= '{wr: w, rd: !w, addr: a, wdata: d, master: m};
        @(posedge clk_sys);
        req <= '0;
    endtask
endmodule

// ==== sim/hgs_gate_semaphore_tb.sv ====
// Purpose: self-checking bench for the gate semaphore
// Assumes: 20 MHz clock, sync reset
// Notes:   none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin error_cnt++; \
    $display("ERROR %s expected %h seen %h", n, e, s); end end
module hgs_gate_semaphore_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import hgs_pkg::*;
    logic        clk_sys = 0;
    logic        rst = 1;
    hgs_req_type req;
    hgs_rsp_type rsp;
    hgs_clr_type clr = '0;
    logic        clr_armed;
    logic [15:0] gate_locked;
    int          error_cnt = 0;
    int          comparisons = 0;
    always #25 clk_sys = ~clk_sys;
    hgs_core_model cpu (.clk_sys(clk_sys), .req(req));
    hgs_gate_semaphore dut (.clk_sys(clk_sys), .rst(rst), .req(req), .rsp(rsp), .clr(clr),
        .clr_armed(clr_armed), .gate_locked(gate_locked));
    task automatic wr_chk(input logic [3:0] a, input logic [7:0] d, input logic [3:0] m,
                          input logic e);
        cpu.access(1'b1, a, d, m);
        #1 `CHK("werr", e, rsp.werr)
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        cpu.access(1'b0, a, 8'h00, 4'h0);
        #1 `CHK("gate state", e, rsp.rdata)
        `CHK("rvalid", 1'b1, rsp.rvalid)
    endtask
    task automatic clr_step(input logic al, input logic [3:0] g, input logic [7:0] k);
        @(posedge clk_sys);
        clr <= '{valid: 1'b1, all: al, gate: g, key: k};
        @(posedge clk_sys);
        clr <= '0;
    endtask
    task automatic t_lock();
        wr_chk(4'h3, 8'h03, 4'h2, 1'b0);
        rd_chk(4'h3, 8'h03);
        wr_chk(4'h3, 8'h00, 4'h5, 1'b1);
        wr_chk(4'h3, 8'h06, 4'h5, 1'b1);
        rd_chk(4'h3, 8'h03);
        wr_chk(4'h3, 8'h00, 4'h2, 1'b0);
        rd_chk(4'h3, 8'h00);
        wr_chk(4'h4, 8'h43, 4'h2, 1'b1);
    endtask
    task automatic t_clear();
        for (int g = 0; g < 16; g++) wr_chk(g[3:0], 8'h02, 4'h1, 1'b0);
        @(posedge clk_sys);
        #1 `CHK("locked", 16'hffff, gate_locked)
        clr_step(1'b0, 4'h5, 8'he2);
        @(posedge clk_sys);
        #1 `CHK("armed", 1'b1, clr_armed)
        clr_step(1'b0, 4'h5, 8'h1d);
        rd_chk(4'h5, 8'h00);
        `CHK("armed", 1'b0, clr_armed)
        rd_chk(4'h6, 8'h02);
        clr_step(1'b1, 4'h0, 8'he2);
        clr_step(1'b1, 4'h0, 8'h1d);
        repeat (2) @(posedge clk_sys);
        #1 `CHK("locked", 16'h0000, gate_locked)
    endtask
    task automatic t_refuse();
        wr_chk(4'h7, 8'h00, 4'hf, 1'b1);
        rd_chk(4'h7, 8'h00);
        clr_step(1'b1, 4'h0, 8'h55);
        @(posedge clk_sys);
        #1 `CHK("armed", 1'b0, clr_armed)
        wr_chk(4'h7, 8'h01, 4'h0, 1'b0);
        clr_step(1'b0, 4'h7, 8'h1d);
        rd_chk(4'h7, 8'h01);
    endtask
    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_lock();
        t_clear();
        t_refuse();
        conclude();
    end
endmodule
